// *** cma_pkg.sv ***
// Package of constants and types for the core memory address map block
package cma_pkg;
    // ==========================================
    // Program space
    localparam int          PROG_AW          = 24;
    localparam int          INSN_W           = 24;
    localparam logic [23:0] RESET_VECTOR     = 24'h000000;
    localparam logic [23:0] RESET_TARGET     = 24'h000002;
    localparam logic [23:0] PRI_IVT_LO       = 24'h000004;
    localparam logic [23:0] PRI_IVT_HI       = 24'h0000ff;
    localparam logic [23:0] ALT_IVT_LO       = 24'h000100;
    localparam logic [23:0] ALT_IVT_HI       = 24'h0001ff;
    localparam logic [23:0] VECTOR_END       = 24'h000200;
    localparam logic [23:0] PC_STEP          = 24'h000002;
    localparam logic [23:0] CFG_5K5          = 24'h002bfc;
    localparam logic [23:0] CFG_11K          = 24'h0057fc;
    localparam logic [23:0] CFG_16K          = 24'h0083fc;
    localparam logic [23:0] CFG_22K          = 24'h00abfc;
    localparam logic [23:0] CFG_WORD_STEP    = 24'h000002;
    // ==========================================
    // Data space
    localparam int          DATA_AW          = 16;
    localparam logic [15:0] DATA_IMPL_TOP    = 16'h1fff;
    localparam logic [15:0] SFR_TOP          = 16'h07ff;
    localparam logic [15:0] NEAR_TOP         = 16'h1fff;
    localparam int          DATA_WORDS       = 4096;
    localparam int          SFR_WORDS        = 1024;
    localparam logic [15:0] BYTE_STEP        = 16'h0001;
    localparam logic [15:0] WORD_STEP        = 16'h0002;
    localparam logic [15:0] RESET_DATA       = 16'h0000;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        CMA_MEM_5K5 = 2'h0,
        CMA_MEM_11K = 2'h1,
        CMA_MEM_16K = 2'h2,
        CMA_MEM_22K = 2'h3
    } cma_mem_size_t;

    typedef enum logic [2:0] {
        CMA_ST_CFG_LO = 3'b001,
        CMA_ST_CFG_HI = 3'b010,
        CMA_ST_RUN    = 3'b100
    } cma_state_t;

    typedef enum logic [1:0] {
        CMA_EXT_NONE = 2'h0,
        CMA_EXT_SIGN = 2'h1,
        CMA_EXT_ZERO = 2'h2
    } cma_ext_t;

    // Configuration word address for a memory size
    function automatic logic [23:0] cma_cfg_addr(input cma_mem_size_t sz);
        case (sz)
            CMA_MEM_5K5: cma_cfg_addr = CFG_5K5;
            CMA_MEM_11K: cma_cfg_addr = CFG_11K;
            CMA_MEM_16K: cma_cfg_addr = CFG_16K;
            default:     cma_cfg_addr = CFG_22K;
        endcase
    endfunction : cma_cfg_addr
endpackage : cma_pkg

// *** cma_agu_if.sv ***
// Interface carrying one address generation unit request and its result
`timescale 1ns/1ps
interface cma_agu_if;
    logic        valid;
    logic        byte_op;
    logic        post_inc;
    logic [15:0] pointer;
    logic [15:0] address;
    logic [15:0] next_pointer;
    logic        misaligned;
    logic        implemented;
    logic        in_sfr;
    logic        in_psv;
    modport agu  (input valid, byte_op, post_inc, pointer,
                  output address, next_pointer, misaligned, implemented, in_sfr, in_psv);
    modport core (output valid, byte_op, post_inc, pointer,
                  input address, next_pointer, misaligned, implemented, in_sfr, in_psv);
endinterface : cma_agu_if

// *** cma_agu.sv ***
// Address generation unit: effective address, scaled post-increment, decode
`timescale 1ns/1ps
module cma_agu (
    cma_agu_if.agu port_if
);
    import cma_pkg::*;
    wire [15:0] step_w = port_if.byte_op ? BYTE_STEP : WORD_STEP;

    assign port_if.address      = port_if.pointer;
    assign port_if.next_pointer = port_if.post_inc ? port_if.pointer + step_w : port_if.pointer;
    assign port_if.misaligned   = port_if.valid && !port_if.byte_op && port_if.pointer[0];
    assign port_if.in_psv       = port_if.pointer[15];
    assign port_if.implemented  = !port_if.pointer[15] && (port_if.pointer <= DATA_IMPL_TOP);
    assign port_if.in_sfr       = port_if.pointer <= SFR_TOP;
endmodule : cma_agu

// *** cma_byte_ram.sv ***
// Data memory of two byte lanes with shared word decode
`timescale 1ns/1ps
module cma_byte_ram #(
    parameter int WORDS = 4096,
    parameter int AW    = 12
) (
    input  wire logic          i_clk,
    input  wire logic [AW-1:0] i_rd_word,
    output logic      [15:0]   o_rd_data,
    input  wire logic [AW-1:0] i_wr_word,
    input  wire logic [1:0]    i_wr_lane,
    input  wire logic [15:0]   i_wr_data
);
    logic [7:0] lane_q [2][WORDS];

    for (genvar g = 0; g < 2; g++) begin : g_lane
        always_ff @(posedge i_clk) begin
            if (i_wr_lane[g]) begin
                lane_q[g][i_wr_word] <= i_wr_data[g*8 +: 8];
            end
        end
    end

    assign o_rd_data = {lane_q[1][i_rd_word], lane_q[0][i_rd_word]};
endmodule : cma_byte_ram

// *** cma_core_memory_map.sv ***
// Top of the core memory address map: program fetch, configuration copy, data access
`timescale 1ns/1ps
// Notes on behaviour
// - Program location is 24-bit word; lower even, upper odd, top byte absent.
// - Program counter stays even and steps by two per instruction.
// - Addresses below 000200h hold only vectors, not user code.
// - Fetch starts at zero; jump there uses operand word at 000002h.
// - Primary vector table 000004h-0000FFh, alternate 000100h-0001FFh.
// - Top two program words copied into configuration registers each reset.
// - Configuration pair address follows program memory size.
// - Copy scatters stored bits into separate registers, reordered.
// - Data addresses are 16 bits, byte granular, 64 Kbytes.
// - Separate read and write address generation units.
// - Bit 15 clear is data memory; set is program visibility window.
// - Reads with bit 15 clear outside the 8 Kbyte implemented area return zero.
// - Low byte at even address, high byte at odd.
// - Post-increment steps 1 for bytes, 2 for words.
// - Byte read fetches word, address bit 0 picks byte, placed low.
// - Shared word decode, per-byte write enables.
// - Odd word access traps; misaligned read completes first.
// - Misaligned write executes with write suppressed, then traps.
// - Byte load alters only working register low byte.
// - Sign-extend 8 to 16 bits; zero-extend clears high byte.
// - Near space direct via 13-bit field; rest indirect except move.
// - Move instruction has direct 16-bit address field.
// - Low 2 Kbytes are registers; unimplemented ones read zero.
module cma_core_memory_map
    import cma_pkg::*;
#(
    parameter int NUM_WREG = 16
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    input  wire cma_pkg::cma_mem_size_t i_mem_size,
    // Program memory port
    output logic [23:0]                 o_prog_addr,
    input  wire logic [23:0]            i_prog_data,
    input  wire logic [23:0]            i_pc_target,
    input  wire logic                   i_pc_load,
    input  wire logic                   i_pc_advance,
    input  wire logic                   i_pc_retreat,
    output logic [23:0]                 o_program_counter,
    output logic [15:0]                 o_insn_lower,
    output logic [7:0]                  o_insn_upper,
    output logic                        o_in_vector_area,
    output logic                        o_in_alt_table,
    output logic                        o_cfg_done,
    output logic [7:0]                  o_cfg_reg_a,
    output logic [7:0]                  o_cfg_reg_b,
    output logic [7:0]                  o_cfg_reg_c,
    output logic [7:0]                  o_cfg_reg_d,
    output logic [7:0]                  o_cfg_reg_e,
    output logic [7:0]                  o_cfg_reg_f,
    // Data read request
    input  wire logic                   i_rd_valid,
    input  wire logic                   i_rd_byte,
    input  wire logic                   i_rd_post_inc,
    input  wire logic                   i_rd_direct,
    input  wire logic                   i_rd_move,
    input  wire logic [15:0]            i_rd_addr,
    input  wire logic [15:0]            i_psv_data,
    input  wire logic [15:0]            i_sfr_data,
    input  wire logic                   i_sfr_hit,
    output logic [15:0]                 o_rd_data,
    output logic [15:0]                 o_rd_next_ptr,
    output logic                        o_rd_valid,
    // Data write request
    input  wire logic                   i_wr_valid,
    input  wire logic                   i_wr_byte,
    input  wire logic                   i_wr_post_inc,
    input  wire logic                   i_wr_direct,
    input  wire logic                   i_wr_move,
    input  wire logic [15:0]            i_wr_addr,
    input  wire logic [15:0]            i_wr_data,
    output logic [15:0]                 o_wr_next_ptr,
    output logic                        o_wr_done,
    // Working register load
    input  wire logic                   i_wreg_load,
    input  wire logic [3:0]             i_wreg_sel,
    input  wire logic                   i_wreg_byte,
    input  wire cma_pkg::cma_ext_t      i_wreg_ext,
    input  wire logic [15:0]            i_wreg_data,
    output logic [15:0]                 o_wreg_value,
    // Trap
    output logic                        o_addr_trap
);
    import cma_pkg::*;

    // ==========================================
    // Reset synchroniser
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // ==========================================
    // Configuration copy and program counter
    cma_state_t  state_q;
    cma_state_t  state_d;
    logic [23:0] pc_q;
    logic [23:0] pc_d;
    logic [15:0] cfg_lo_q;
    logic [7:0]  cfg_a_q, cfg_b_q, cfg_c_q, cfg_d_q, cfg_e_q, cfg_f_q;
    logic        cfg_done_q;

    wire [23:0] cfg_addr_w = cma_cfg_addr(i_mem_size);
    // Held off until the copy lands so early core pulses stay ignored
    wire        running_w  = (state_q == CMA_ST_RUN) && cfg_done_q;
    wire [23:0] fetch_addr_w = (state_q == CMA_ST_CFG_LO) ? cfg_addr_w :
                               (state_q == CMA_ST_CFG_HI) ? cfg_addr_w + CFG_WORD_STEP : pc_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CMA_ST_CFG_LO: state_d = CMA_ST_CFG_HI;
            CMA_ST_CFG_HI: state_d = CMA_ST_RUN;
            CMA_ST_RUN:    state_d = CMA_ST_RUN;
            default:       state_d = CMA_ST_CFG_LO;
        endcase
    end

    assign pc_d = !running_w   ? pc_q :
                  i_pc_load    ? {i_pc_target[23:1], 1'b0} :
                  i_pc_advance ? pc_q + PC_STEP :
                  i_pc_retreat ? pc_q - PC_STEP : pc_q;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CMA_ST_CFG_LO;
            pc_q    <= RESET_VECTOR;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_lo_q   <= 16'h0000;
            cfg_a_q    <= 8'h00;
            cfg_b_q    <= 8'h00;
            cfg_c_q    <= 8'h00;
            cfg_d_q    <= 8'h00;
            cfg_e_q    <= 8'h00;
            cfg_f_q    <= 8'h00;
            cfg_done_q <= 1'b0;
        // Reply trails the registered fetch address by one state
        end else if (state_q == CMA_ST_CFG_HI) begin
            cfg_lo_q <= i_prog_data[15:0];
        end else if ((state_q == CMA_ST_RUN) && !cfg_done_q) begin
            cfg_a_q    <= {cfg_lo_q[3:0], cfg_lo_q[15:12]};
            cfg_b_q    <= {cfg_lo_q[7:4], cfg_lo_q[11:8]};
            cfg_c_q    <= {i_prog_data[0], i_prog_data[1], i_prog_data[2], i_prog_data[3],
                           i_prog_data[4], i_prog_data[5], i_prog_data[6], i_prog_data[7]};
            cfg_d_q    <= i_prog_data[15:8];
            cfg_e_q    <= {cfg_lo_q[11:8], cfg_lo_q[15:12]};
            cfg_f_q    <= {cfg_lo_q[7:0]};
            cfg_done_q <= 1'b1;
        end
    end

    // ==========================================
    // Program fetch outputs
    logic [15:0] insn_lo_q;
    logic [7:0]  insn_hi_q;
    logic        vec_area_q;
    logic        alt_tab_q;
    logic [23:0] prog_addr_q;

    wire vec_w = pc_q < VECTOR_END;
    wire alt_w = (pc_q >= ALT_IVT_LO) && (pc_q <= ALT_IVT_HI);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr_q <= RESET_VECTOR;
            insn_lo_q   <= 16'h0000;
            insn_hi_q   <= 8'h00;
            vec_area_q  <= 1'b0;
            alt_tab_q   <= 1'b0;
        end else begin
            prog_addr_q <= fetch_addr_w;
            insn_lo_q   <= i_prog_data[15:0];
            insn_hi_q   <= i_prog_data[23:16];
            vec_area_q  <= running_w && vec_w;
            alt_tab_q   <= running_w && alt_w;
        end
    end

    // ==========================================
    // Address generation units
    cma_agu_if rd_if ();
    cma_agu_if wr_if ();

    wire [15:0] rd_ea_w = (i_rd_direct && !i_rd_move) ? {3'b000, i_rd_addr[12:0]} : i_rd_addr;
    wire [15:0] wr_ea_w = (i_wr_direct && !i_wr_move) ? {3'b000, i_wr_addr[12:0]} : i_wr_addr;

    assign rd_if.valid    = i_rd_valid;
    assign rd_if.byte_op  = i_rd_byte;
    assign rd_if.post_inc = i_rd_post_inc;
    assign rd_if.pointer  = rd_ea_w;
    assign wr_if.valid    = i_wr_valid;
    assign wr_if.byte_op  = i_wr_byte;
    assign wr_if.post_inc = i_wr_post_inc;
    assign wr_if.pointer  = wr_ea_w;

    cma_agu u_rd_agu (.port_if(rd_if));
    cma_agu u_wr_agu (.port_if(wr_if));

    // ==========================================
    // Data memory
    logic [15:0] ram_rd_w;
    wire wr_ok_w = i_wr_valid && !wr_if.misaligned && wr_if.implemented && !wr_if.in_sfr;
    wire [1:0]  lane_w  = !wr_ok_w ? 2'b00 : !i_wr_byte ? 2'b11 : (wr_ea_w[0] ? 2'b10 : 2'b01);
    wire [15:0] wdata_w = i_wr_byte ? {i_wr_data[7:0], i_wr_data[7:0]} : i_wr_data;

    cma_byte_ram #(.WORDS(DATA_WORDS), .AW(12)) u_ram (
        .i_clk     (i_core_clk),
        .i_rd_word (rd_ea_w[12:1]),
        .o_rd_data (ram_rd_w),
        .i_wr_word (wr_ea_w[12:1]),
        .i_wr_lane (lane_w),
        .i_wr_data (wdata_w)
    );

    wire [15:0] sfr_w  = i_sfr_hit ? i_sfr_data : RESET_DATA;
    wire [15:0] word_w = rd_if.in_psv ? i_psv_data : !rd_if.implemented ? RESET_DATA :
                         rd_if.in_sfr ? sfr_w : ram_rd_w;
    wire [15:0] rd_w   = i_rd_byte ? {8'h00, (rd_ea_w[0] ? word_w[15:8] : word_w[7:0])} : word_w;

    logic [15:0] rd_data_q, rd_ptr_q, wr_ptr_q;
    logic        rd_valid_q, wr_done_q, trap_q;
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q  <= RESET_DATA;
            rd_ptr_q   <= RESET_DATA;
            wr_ptr_q   <= RESET_DATA;
            rd_valid_q <= 1'b0;
            wr_done_q  <= 1'b0;
            trap_q     <= 1'b0;
        end else begin
            rd_data_q  <= rd_w;
            rd_ptr_q   <= rd_if.next_pointer;
            wr_ptr_q   <= wr_if.next_pointer;
            rd_valid_q <= i_rd_valid;
            wr_done_q  <= i_wr_valid;
            trap_q     <= rd_if.misaligned || wr_if.misaligned;
        end
    end

    // ==========================================
    // Working registers
    logic [15:0] wreg_q [NUM_WREG];
    logic [15:0] wreg_out_q;
    wire  [15:0] wold_w = wreg_q[i_wreg_sel];
    wire  [15:0] wnew_w = (i_wreg_ext == CMA_EXT_SIGN) ? {{8{i_wreg_data[7]}}, i_wreg_data[7:0]} :
                          (i_wreg_ext == CMA_EXT_ZERO) ? {8'h00, i_wreg_data[7:0]} :
                          i_wreg_byte ? {wold_w[15:8], i_wreg_data[7:0]} : i_wreg_data;

    for (genvar g = 0; g < NUM_WREG; g++) begin : g_wreg
        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                wreg_q[g] <= RESET_DATA;
            end else if (i_wreg_load && (i_wreg_sel == 4'(g))) begin
                wreg_q[g] <= wnew_w;
            end
        end
    end
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wreg_out_q <= RESET_DATA;
        end else begin
            wreg_out_q <= i_wreg_load ? wnew_w : wold_w;
        end
    end

    // ==========================================
    // Outputs
    assign o_prog_addr       = prog_addr_q;
    assign o_program_counter = pc_q;
    assign o_insn_lower      = insn_lo_q;
    assign o_insn_upper      = insn_hi_q;
    assign o_in_vector_area  = vec_area_q;
    assign o_in_alt_table    = alt_tab_q;
    assign o_cfg_done        = cfg_done_q;
    assign o_cfg_reg_a       = cfg_a_q;
    assign o_cfg_reg_b       = cfg_b_q;
    assign o_cfg_reg_c       = cfg_c_q;
    assign o_cfg_reg_d       = cfg_d_q;
    assign o_cfg_reg_e       = cfg_e_q;
    assign o_cfg_reg_f       = cfg_f_q;
    assign o_rd_data         = rd_data_q;
    assign o_rd_next_ptr     = rd_ptr_q;
    assign o_rd_valid        = rd_valid_q;
    assign o_wr_next_ptr     = wr_ptr_q;
    assign o_wr_done         = wr_done_q;
    assign o_wreg_value      = wreg_out_q;
    assign o_addr_trap       = trap_q;

    // ==========================================
    // Checks
    chk_pc_even: assert property (@(posedge i_core_clk) disable iff (!rst_n) !pc_q[0])
        else $error("program counter odd");
    chk_pc_step: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        running_w && !i_pc_load && i_pc_advance |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("program counter step wrong");
    chk_trap_raise: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_rd_valid && !i_rd_byte && rd_ea_w[0] |=> o_addr_trap)
        else $error("misaligned read no trap");
    chk_wr_suppress: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_wr_valid && !i_wr_byte && wr_ea_w[0] |-> lane_w == 2'b00 ##1 o_addr_trap)
        else $error("misaligned write not suppressed");
    chk_unimpl_zero: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_rd_valid && !rd_ea_w[15] && rd_ea_w > DATA_IMPL_TOP |=> o_rd_data == 16'h0000)
        else $error("unimplemented read nonzero");
    // Sampled reset term skips the release edge, where the pointer flop is still cleared
    chk_byte_step: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        rst_n && i_rd_post_inc |=> o_rd_next_ptr == $past(rd_ea_w) + ($past(i_rd_byte) ? BYTE_STEP : WORD_STEP))
        else $error("pointer step wrong");
    chk_byte_low: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_rd_valid && i_rd_byte |=> o_rd_data[15:8] == 8'h00)
        else $error("byte read high lane nonzero");
    chk_cfg_copy: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        rst_n && state_q == CMA_ST_CFG_LO |-> ##3 o_cfg_done)
        else $error("config copy late");
    chk_wreg_high: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_wreg_load && i_wreg_byte && i_wreg_ext == CMA_EXT_NONE |=> o_wreg_value[15:8] == $past(wold_w[15:8]))
        else $error("byte load changed high byte");
endmodule : cma_core_memory_map

// *** cma_prog_model.sv ***
// Program memory responder for the address map bench
`timescale 1ns/1ps
module cma_prog_model (
    input  wire logic [23:0] i_addr,
    output logic      [23:0] o_data
);
    // ==========================================
    // Reply
    // one word per address
    assign o_data = {i_addr[7:0] ^ 8'h5a, i_addr[15:0] ^ 16'ha5c3};
endmodule : cma_prog_model

// *** tb_top.sv ***
// Self-checking bench for the core memory address map
`timescale 1ns/1ps
module tb_top;
    import cma_pkg::*;
    // ==========================================
    // Signals and model state
    logic          clk = 1'b0, rst_n = 1'b0, ld = 1'b0, adv = 1'b0, ret = 1'b0, hit = 1'b0;
    logic          rv = 1'b0, rb = 1'b0, rpi = 1'b0, rdr = 1'b0, rmv = 1'b0, wl = 1'b0, wby = 1'b0;
    logic          wv = 1'b0, wb = 1'b0, wpi = 1'b0, wdr = 1'b0, wmv = 1'b0;
    logic [15:0]   ra = 16'h0, wa = 16'h0, wd = 16'h0, psv = 16'h0, special_function_register = 16'h0, wdt = 16'h0;
    logic [3:0]    ws = 4'h0;
    logic [23:0]   pct = 24'h0, pd, pa, pc, mpc;
    logic [23:0]   ct [4] = '{24'h002bfc, 24'h0057fc, 24'h0083fc, 24'h00abfc};
    logic [15:0]   il, rdd, rnp, wnp, wvo, wr [0:15];
    logic [7:0]    iu, mem [0:8191];
    logic          iva, iat, done, rvo, wdn, trap;
    logic [7:0]    ca, cb, cc, cd, ce, cf;
    cma_mem_size_t msz = CMA_MEM_5K5;
    cma_ext_t      ext = CMA_EXT_NONE;
    integer        seed = 42486, bad_count = 0, samples_checked = 0;
    // ==========================================
    // Design and far side
    cma_prog_model u_cma_prog_model (.i_addr(pa), .o_data(pd));
    cma_core_memory_map u_cma_core_memory_map (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_mem_size(msz), .o_prog_addr(pa), .i_prog_data(pd),
        .i_pc_target(pct), .i_pc_load(ld), .i_pc_advance(adv), .i_pc_retreat(ret), .o_program_counter(pc),
        .o_insn_lower(il), .o_insn_upper(iu), .o_in_vector_area(iva), .o_in_alt_table(iat), .o_cfg_done(done),
        .o_cfg_reg_a(ca), .o_cfg_reg_b(cb), .o_cfg_reg_c(cc), .o_cfg_reg_d(cd), .o_cfg_reg_e(ce),
        .o_cfg_reg_f(cf),
        .i_rd_valid(rv), .i_rd_byte(rb), .i_rd_post_inc(rpi), .i_rd_direct(rdr), .i_rd_move(rmv),
        .i_rd_addr(ra), .i_psv_data(psv), .i_sfr_data(special_function_register), .i_sfr_hit(hit), .o_rd_data(rdd),
        .o_rd_next_ptr(rnp), .o_rd_valid(rvo), .i_wr_valid(wv), .i_wr_byte(wb), .i_wr_post_inc(wpi),
        .i_wr_direct(wdr), .i_wr_move(wmv), .i_wr_addr(wa), .i_wr_data(wd), .o_wr_next_ptr(wnp),
        .o_wr_done(wdn), .i_wreg_load(wl), .i_wreg_sel(ws), .i_wreg_byte(wby), .i_wreg_ext(ext),
        .i_wreg_data(wdt), .o_wreg_value(wvo), .o_addr_trap(trap));
    always #2 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // Pulses during the copy must be ignored
    task automatic rst(input cma_mem_size_t s, input logic [23:0] c);
        logic        lo, hi;
        logic [15:0] l, h;
        logic [7:0]  rev;
        {lo, hi} = 2'b00;
        l = c[15:0] ^ 16'ha5c3;
        h = 16'(c + 24'h2) ^ 16'ha5c3;
        for (int i = 0; i < 8; i++) rev[i] = h[7 - i];
        msz = s;
        rst_n = 1'b0;
        {wv, rv, wl, ld, adv, ret} = 6'b000010;
        repeat (2) cyc();
        chk("rst_pc", 24'h0, pc);
        rst_n = 1'b1;
        for (int i = 0; i < 20 && done !== 1'b1; i++) begin
            cyc();
            lo |= (pa === c);
            hi |= (pa === c + 24'h2);
        end
        mpc = 24'h0;
        chk("cfg_words", 24'h3, {22'h0, lo, hi});
        chk("pc_start", 24'h0, pc);
        chk("cfg_abc", {l[3:0], l[15:12], l[7:4], l[11:8], rev}, {ca, cb, cc});
        chk("cfg_def", {h[15:8], l[11:8], l[15:12], l[7:0]}, {cd, ce, cf});
    endtask : rst
    // Byte writes repeat the byte so either lane choice sees it
    task automatic dop(input logic w, b, pi, dr, mv, input logic [15:0] a);
        logic [15:0] e, x;
        logic        ms;
        e = (dr && !mv) ? (a & 16'h1fff) : a;
        ms = !b && e[0];
        x = 16'($random(seed));
        {psv, special_function_register, hit} = {16'($random(seed)), 16'($random(seed)), 1'($random(seed))};
        wd = b ? {x[7:0], x[7:0]} : x;
        {wv, rv, wl, ld, adv, ret} = {w, !w, 4'h0};
        if (w) {wb, wpi, wdr, wmv, wa} = {b, pi, dr, mv, a};
        else {rb, rpi, rdr, rmv, ra} = {b, pi, dr, mv, a};
        x = e[15] ? psv : (e <= 16'h07ff) ? (hit ? special_function_register : 16'h0)
          : (e <= 16'h1fff) ? {mem[e | 16'h1], mem[e & 16'h1ffe]} : 16'h0;
        if (b) x = {8'h00, e[0] ? x[15:8] : x[7:0]};
        cyc();
        chk("trap", 24'(ms), 24'(trap));
        if (pi && !dr) chk("next_ptr", 24'(a + (b ? 16'h1 : 16'h2)), 24'(w ? wnp : rnp));
        if (!w) chk("rd_valid", 24'h1, 24'(rvo));
        if (!w && !ms) chk("rd_data", 24'(x), 24'(rdd));
        if (w && !ms) chk("wr_done", 24'h1, 24'(wdn));
        if (w && !ms && e >= 16'h0800 && e <= 16'h1fff) mem[e] = wd[7:0];
        if (w && !ms && !b && e >= 16'h0800 && e <= 16'h1fff) mem[e | 16'h1] = wd[15:8];
    endtask : dop
    task automatic pcop(input logic [2:0] k, input logic [23:0] t);
        {wv, rv, wl, ld, adv, ret} = {3'b000, k};
        pct = t;
        mpc = k[2] ? {t[23:1], 1'b0} : k[1] ? mpc + 24'h2 : k[0] ? mpc - 24'h2 : mpc;
        cyc();
        {ld, adv, ret} = 3'b000;
        chk("pc", mpc, pc);
        cyc();
        chk("prog_addr", mpc, pa);
        chk("vec_area", 24'(mpc < 24'h200), 24'(iva));
        chk("alt_table", 24'(mpc >= 24'h100 && mpc <= 24'h1ff), 24'(iat));
        cyc();
        chk("insn", {mpc[7:0] ^ 8'h5a, mpc[15:0] ^ 16'ha5c3}, {iu, il});
    endtask : pcop
    task automatic wrg(input logic [3:0] s, input logic b, input cma_ext_t x);
        {wv, rv, wl, ld, adv, ret} = 6'b001000;
        {ws, wby, wdt} = {s, b, 16'($random(seed))};
        ext = x;
        wr[s] = (x == CMA_EXT_SIGN) ? {{8{wdt[7]}}, wdt[7:0]} : (x == CMA_EXT_ZERO) ? {8'h00, wdt[7:0]}
              : b ? {wr[s][15:8], wdt[7:0]} : wdt;
        cyc();
        chk("wreg", 24'(wr[s]), 24'(wvo));
    endtask : wrg
    // ==========================================
    // Sequence
    initial begin
        logic [15:0] a;
        logic [31:0] r;
        cma_ext_t    x;
        for (int s = 0; s < 4; s++) rst(cma_mem_size_t'(s), ct[s]);
        for (int i = 16'h0800; i < 16'h2000; i += 2) dop(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'(i));
        for (int i = 0; i < 16; i++) wrg(4'(i), 1'b0, CMA_EXT_NONE);
        repeat (3000) begin
            r = $random(seed);
            a = 16'($random(seed));
            if (!a[15]) a[14] = 1'b0;
            x = (r[9:8] == 2'h1) ? CMA_EXT_SIGN : (r[9:8] == 2'h2) ? CMA_EXT_ZERO : CMA_EXT_NONE;
            case (r[1:0])
                2'h0, 2'h1: dop(r[0], r[4], r[5], r[6] && !r[5], r[7], a);
                2'h2: pcop(r[14:12], {14'h0, r[25:16]});
                default: wrg(r[23:20], r[10] && x == CMA_EXT_NONE, x);
            endcase
        end
        wrap_up();
    end
    // Generous span for a hang
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule : tb_top
